// ==== verilog/sre_pkg.sv ====
// constants and types shared by the statistics record exporter
package sre_pkg;
	localparam int ING_REC_BYTES = 6;
	localparam int EGR_REC_BYTES = 4;
	localparam int MAX_REC_BYTES = 8;
	localparam int REC_DW = MAX_REC_BYTES * 8;
	localparam int LEN_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int FRAME_RECS = 8;
	localparam int PREAMBLE_BYTES = 8;
	localparam int FCS_BYTES = 4;
	localparam int IPG_BYTES = 12;
	localparam int FIRST_STATS_LANE = 32;
	localparam int LAST_STATS_LANE = 39;
	localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [7:0] LANE_MASK_SINGLE = 8'h0f;
	localparam logic [7:0] LANE_MASK_DUAL = 8'hff;
	localparam logic RST_DUAL = 1'b0;
	typedef enum logic [1:0] {SRE_OPT_QSIZE, SRE_OPT_BILLING, SRE_OPT_ENQDEQ} sre_option_t;
	typedef enum logic [1:0] {SRE_EV_ENQ, SRE_EV_DEQ, SRE_EV_RX, SRE_EV_TX} sre_event_t;
	localparam sre_option_t RST_OPTION = SRE_OPT_QSIZE;
endpackage

// ==== verilog/sre_rec_if.sv ====
// record handshake between the record source and one port framer
interface sre_rec_if #(parameter int DW = 64, parameter int LW = 4);
	logic valid;
	logic ready;
	logic [DW-1:0] data;
	logic [LW-1:0] len;
	modport src (output valid, output data, output len, input ready);
	modport sink (input valid, input data, input len, output ready);
endinterface

// ==== verilog/sre_rec_fifo.sv ====
// flip-flop record fifo with valid/ready on both sides
module sre_rec_fifo #(
	parameter int W = 68,
	parameter int DEPTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_push_valid,
	output logic o_push_ready,
	input wire logic [W-1:0] i_push_data,
	output logic o_pop_valid,
	input wire logic i_pop_ready,
	output logic [W-1:0] o_pop_data,
	output logic o_empty
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;
	logic full;
	logic push;
	logic pop;

	assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	assign o_empty = (wp == rp);
	assign o_push_ready = !full;
	assign o_pop_valid = !o_empty;
	assign o_pop_data = mem[rp[AW-1:0]];
	assign push = i_push_valid && !full;
	assign pop = i_pop_ready && !o_empty;

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem[wp[AW-1:0]] <= i_push_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
		end
	end
endmodule // sre_rec_fifo

// ==== verilog/sre_tx_framer.sv ====
// one statistics port: preamble, records, fcs and idle gap, one byte per clock
module sre_tx_framer (
	input wire logic i_clock,
	input wire logic i_rst_n,
	sre_rec_if.sink rec,
	output logic [7:0] o_txd,
	output logic o_txen,
	output logic o_busy
);
	import sre_pkg::*;
	typedef enum {SRE_FS_IDLE, SRE_FS_PRE, SRE_FS_REC, SRE_FS_FCS, SRE_FS_GAP} sre_fstate_t;
	sre_fstate_t state;
	logic [3:0] cnt;
	logic [3:0] rec_cnt;
	logic [REC_DW-1:0] sh;
	logic [LEN_W-1:0] len;
	logic [31:0] crc;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign rec.ready = ((state == SRE_FS_PRE) && (cnt == 4'(PREAMBLE_BYTES - 1)))
		|| ((state == SRE_FS_REC) && (len == 4'h1) && (rec_cnt != 4'(FRAME_RECS - 1)));
	assign o_busy = (state != SRE_FS_IDLE);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state <= SRE_FS_IDLE;
			cnt <= 4'h0;
			rec_cnt <= 4'h0;
			sh <= '0;
			len <= '0;
			crc <= CRC_INIT;
			o_txd <= 8'h00;
			o_txen <= 1'b0;
		end else begin
			case (state)
				SRE_FS_IDLE: begin
					o_txen <= 1'b0;
					cnt <= 4'h0;
					if (rec.valid) begin
						state <= SRE_FS_PRE;
					end
				end
				SRE_FS_PRE: begin
					o_txen <= 1'b1;
					crc <= CRC_INIT;
					rec_cnt <= 4'h0;
					cnt <= cnt + 4'h1;
					if (cnt == 4'(PREAMBLE_BYTES - 1)) begin
						o_txd <= SFD_BYTE;
						cnt <= 4'h0;
						sh <= rec.data;
						len <= rec.len;
						state <= rec.valid ? SRE_FS_REC : SRE_FS_FCS;
					end else begin
						o_txd <= PREAMBLE_BYTE;
					end
				end
				SRE_FS_REC: begin
					o_txen <= 1'b1;
					o_txd <= sh[7:0];
					crc <= crc_byte(crc, sh[7:0]);
					if (len == 4'h1) begin
						if (rec.ready && rec.valid) begin
							sh <= rec.data;
							len <= rec.len;
							rec_cnt <= rec_cnt + 4'h1;
						end else begin
							state <= SRE_FS_FCS;
							cnt <= 4'h0;
						end
					end else begin
						sh <= sh >> 8;
						len <= len - 4'h1;
					end
				end
				SRE_FS_FCS: begin
					o_txen <= 1'b1;
					o_txd <= ~crc[7:0];
					crc <= crc >> 8;
					cnt <= cnt + 4'h1;
					if (cnt == 4'(FCS_BYTES - 1)) begin
						state <= SRE_FS_GAP;
						cnt <= 4'h0;
					end
				end
				SRE_FS_GAP: begin
					o_txen <= 1'b0;
					cnt <= cnt + 4'h1;
					if (cnt == 4'(IPG_BYTES - 1)) begin
						cnt <= 4'h0;
						state <= rec.valid ? SRE_FS_PRE : SRE_FS_IDLE;
					end
				end
				default: begin
					state <= SRE_FS_IDLE;
				end
			endcase
		end
	end
endmodule // sre_tx_framer

// ==== verilog/sre_exporter.sv ====
// statistics record exporter top: filtering, buffering, port mapping and framing
// Overview of operation
// - At most one ingress and one egress record enter per clock, two in all.
// - One reporting option is active for the whole block at a time.
// - Queue-size option records the queue size for each ingress enqueue and dequeue.
// - Billing option records each ingress received and egress transmitted packet with its tag.
// - Enqueue/dequeue option records each ingress enqueue and dequeue with its tag.
// - Single port mode carries ingress and egress records of different sizes on one port.
// - Dual port mode sends ingress records on one port and egress records on the other.
// - A coprocessor far end forces single port mode.
// - Statistics ports map only onto network lanes 32 to 39 of the two port macros.
// - Only the transmit direction of those lanes is used and receive traffic is ignored.
// - Each frame opens with the eight-byte preamble including the start delimiter.
// - Each frame closes with the standard 32-bit Ethernet frame check sequence.
// - Consecutive frames are separated by a twelve-byte idle gap.
module sre_exporter (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input sre_pkg::sre_option_t i_option,
	input wire logic i_dual_mode,
	input wire logic i_far_end_coproc,
	input wire logic i_ing_valid,
	input sre_pkg::sre_event_t i_ing_kind,
	input wire logic [23:0] i_ing_qsize,
	input wire logic [39:0] i_ing_tag,
	output logic o_ing_ready,
	input wire logic i_egr_valid,
	input wire logic [23:0] i_egr_tag,
	output logic o_egr_ready,
	output logic [7:0] o_port0_txd,
	output logic o_port0_txen,
	output logic [7:0] o_port1_txd,
	output logic o_port1_txen,
	output logic [7:0] o_lane_enable,
	output sre_pkg::sre_option_t o_active_option,
	output logic o_active_dual
);
	import sre_pkg::*;
	localparam int FW = REC_DW + LEN_W;

	sre_option_t opt;
	logic dual;
	logic cfg_idle;
	logic ing_keep;
	logic egr_keep;
	logic ing_push_ready;
	logic egr_push_ready;
	logic [39:0] ing_payload;
	logic [7:0] ing_hdr;
	logic [7:0] egr_hdr;
	logic [FW-1:0] ing_word;
	logic [FW-1:0] egr_word;
	logic ing_v;
	logic egr_v;
	logic ing_pop;
	logic egr_pop;
	logic ing_empty;
	logic egr_empty;
	logic [FW-1:0] ing_q;
	logic [FW-1:0] egr_q;
	logic sel_egr;
	logic rr;
	logic busy0;
	logic busy1;

	sre_rec_if #(.DW(REC_DW), .LW(LEN_W)) p0_if ();
	sre_rec_if #(.DW(REC_DW), .LW(LEN_W)) p1_if ();

	// configuration is taken only when the pipeline is drained
	assign cfg_idle = ing_empty && egr_empty && !busy0 && !busy1;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			opt <= RST_OPTION;
		end else if (cfg_idle && (i_option != sre_option_t'(2'h3))) begin
			opt <= i_option;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			dual <= RST_DUAL;
		end else if (cfg_idle) begin
			dual <= i_dual_mode && !i_far_end_coproc;
		end
	end

	// lanes 32..35 sit in macro a, lanes 36..39 in macro b; tx only
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_lane_enable <= LANE_MASK_SINGLE;
		end else begin
			o_lane_enable <= dual ? LANE_MASK_DUAL : LANE_MASK_SINGLE;
		end
	end

	assign o_active_option = opt;
	assign o_active_dual = dual;

	// option filter on the ingress event stream
	always_comb begin
		case (opt)
			SRE_OPT_QSIZE: ing_keep = (i_ing_kind == SRE_EV_ENQ) || (i_ing_kind == SRE_EV_DEQ);
			SRE_OPT_BILLING: ing_keep = (i_ing_kind == SRE_EV_RX);
			SRE_OPT_ENQDEQ: ing_keep = (i_ing_kind == SRE_EV_ENQ) || (i_ing_kind == SRE_EV_DEQ);
			default: ing_keep = 1'b0;
		endcase
	end

	assign egr_keep = (opt == SRE_OPT_BILLING);
	assign ing_payload = (opt == SRE_OPT_QSIZE) ? {16'h0000, i_ing_qsize} : i_ing_tag;
	assign ing_hdr = {1'b0, opt, i_ing_kind, 3'h0};
	assign egr_hdr = {1'b1, opt, SRE_EV_TX, 3'h0};
	assign ing_word = {4'(ING_REC_BYTES), 16'h0000, ing_payload, ing_hdr};
	assign egr_word = {4'(EGR_REC_BYTES), 32'h00000000, i_egr_tag, egr_hdr};
	assign o_ing_ready = ing_push_ready;
	assign o_egr_ready = egr_push_ready;

	// one fifo per direction, one push each per clock
	sre_rec_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_ing_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_push_valid(i_ing_valid && ing_keep),
		.o_push_ready(ing_push_ready),
		.i_push_data(ing_word),
		.o_pop_valid(ing_v),
		.i_pop_ready(ing_pop),
		.o_pop_data(ing_q),
		.o_empty(ing_empty)
	);

	sre_rec_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_egr_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_push_valid(i_egr_valid && egr_keep),
		.o_push_ready(egr_push_ready),
		.i_push_data(egr_word),
		.o_pop_valid(egr_v),
		.i_pop_ready(egr_pop),
		.o_pop_data(egr_q),
		.o_empty(egr_empty)
	);

	// single mode interleaves both directions round robin on port 0
	assign sel_egr = !dual && egr_v && (!ing_v || rr);
	assign p0_if.valid = dual ? ing_v : (ing_v || egr_v);
	assign p0_if.data = sel_egr ? egr_q[REC_DW-1:0] : ing_q[REC_DW-1:0];
	assign p0_if.len = sel_egr ? egr_q[FW-1:REC_DW] : ing_q[FW-1:REC_DW];
	assign p1_if.valid = dual && egr_v;
	assign p1_if.data = egr_q[REC_DW-1:0];
	assign p1_if.len = egr_q[FW-1:REC_DW];
	assign ing_pop = p0_if.ready && !sel_egr;
	assign egr_pop = dual ? p1_if.ready : (p0_if.ready && sel_egr);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rr <= 1'b0;
		end else if (!dual && p0_if.ready && p0_if.valid) begin
			rr <= !sel_egr;
		end
	end

	sre_tx_framer u_port0 (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.rec(p0_if.sink),
		.o_txd(o_port0_txd),
		.o_txen(o_port0_txen),
		.o_busy(busy0)
	);

	sre_tx_framer u_port1 (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.rec(p1_if.sink),
		.o_txd(o_port1_txd),
		.o_txen(o_port1_txen),
		.o_busy(busy1)
	);

	// byte count of the current port 0 frame
	localparam int MAX_FRAME = PREAMBLE_BYTES + FRAME_RECS * ING_REC_BYTES + FCS_BYTES;
	logic [6:0] frame_len;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			frame_len <= 7'h00;
		end else if (o_port0_txen) begin
			frame_len <= frame_len + 7'h01;
		end else begin
			frame_len <= 7'h00;
		end
	end

	default clocking sre_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	chk_ing_push_cause: assert property (
		ing_push_ready && $rose(ing_v) |-> $past(i_ing_valid) && $past(ing_keep))
		else $error("ingress record appeared without an accepted event");

	chk_option_single: assert property (
		$onehot({opt == SRE_OPT_QSIZE, opt == SRE_OPT_BILLING, opt == SRE_OPT_ENQDEQ}))
		else $error("active option is not exactly one");

	chk_qsize_queued: assert property (
		opt == SRE_OPT_QSIZE && i_ing_valid && ing_push_ready && ing_empty
		&& (i_ing_kind == SRE_EV_DEQ) |=> ing_v && (ing_q[31:8] == $past(i_ing_qsize)))
		else $error("queue size record missing or wrong");

	chk_billing_egress: assert property (
		opt == SRE_OPT_BILLING && i_egr_valid && egr_push_ready && egr_empty |=> egr_v)
		else $error("billing egress record lost");

	chk_enqdeq_no_rx: assert property (
		opt != SRE_OPT_BILLING && i_ing_valid && i_ing_kind == SRE_EV_RX && ing_empty
		|=> !ing_v)
		else $error("receive event recorded outside billing option");

	chk_dual_split: assert property (
		dual |-> !p1_if.valid || !sel_egr && (p1_if.valid == egr_v))
		else $error("egress record not on the egress port in dual mode");

	chk_coproc_single: assert property (
		cfg_idle && i_far_end_coproc |=> !dual)
		else $error("dual mode taken with a coprocessor far end");

	chk_lane_mask: assert property (
		1'b1 |=> o_lane_enable == ($past(dual) ? LANE_MASK_DUAL : LANE_MASK_SINGLE))
		else $error("lane enable does not follow port mode");

	chk_preamble_seq: assert property (
		$rose(o_port0_txen) |-> o_port0_txd == PREAMBLE_BYTE [*7] ##1 o_port0_txd == SFD_BYTE)
		else $error("preamble or start delimiter wrong on port 0");

	chk_gap_length: assert property (
		$fell(o_port0_txen) |-> !o_port0_txen [*8] ##1 !o_port0_txen [*4])
		else $error("inter frame gap shorter than twelve bytes");

	chk_cfg_frozen: assert property (
		!cfg_idle |=> $stable(opt) && $stable(dual))
		else $error("configuration changed while records were in flight");

	chk_ready_when_room: assert property (
		!ing_v |-> o_ing_ready)
		else $error("ingress refused while buffer is empty");

	chk_egr_ready_room: assert property (
		!egr_v |-> o_egr_ready)
		else $error("egress refused while buffer is empty");

	chk_frame_bound: assert property (
		o_port0_txen |-> frame_len < 7'(MAX_FRAME))
		else $error("port 0 frame longer than the record limit allows");

	chk_qsize_enqueue: assert property (
		opt == SRE_OPT_QSIZE && i_ing_valid && ing_empty
		&& (i_ing_kind == SRE_EV_ENQ) |=> ing_v && (ing_q[31:8] == $past(i_ing_qsize)))
		else $error("enqueue queue size record missing or wrong");

	chk_billing_rx_tag: assert property (
		opt == SRE_OPT_BILLING && i_ing_valid && ing_empty
		&& (i_ing_kind == SRE_EV_RX) |=> ing_v && (ing_q[47:8] == $past(i_ing_tag)))
		else $error("billing receive record missing or wrong");

	chk_billing_tx_tag: assert property (
		opt == SRE_OPT_BILLING && i_egr_valid && egr_empty
		|=> egr_v && (egr_q[31:8] == $past(i_egr_tag)))
		else $error("billing transmit record missing or wrong");

	chk_egr_other_drop: assert property (
		opt != SRE_OPT_BILLING && i_egr_valid && egr_empty |=> !egr_v)
		else $error("egress record kept outside billing option");

	chk_enqdeq_tag: assert property (
		opt == SRE_OPT_ENQDEQ && i_ing_valid && ing_empty
		&& (i_ing_kind == SRE_EV_DEQ) |=> ing_v && (ing_q[47:8] == $past(i_ing_tag)))
		else $error("dequeue record missing or wrong");

	chk_rec_lengths: assert property (
		(!ing_v || ing_q[FW-1:REC_DW] == 4'(ING_REC_BYTES))
		&& (!egr_v || egr_q[FW-1:REC_DW] == 4'(EGR_REC_BYTES)))
		else $error("record length field wrong");

	chk_single_quiet: assert property (
		!dual |-> !o_port1_txen)
		else $error("port 1 active in single mode");

	chk_code_ignored: assert property (
		cfg_idle && (i_option == sre_option_t'(2'h3)) |=> $stable(opt))
		else $error("unused option code was taken");

	chk_lane_tx_only: assert property (
		o_lane_enable == LANE_MASK_SINGLE || o_lane_enable == LANE_MASK_DUAL)
		else $error("lane enable outside the statistics lanes");

	chk_port1_preamble: assert property (
		$rose(o_port1_txen)
		|-> (o_port1_txd == PREAMBLE_BYTE) [*7] ##1 o_port1_txd == SFD_BYTE)
		else $error("preamble or start delimiter wrong on port 1");

	chk_port1_gap: assert property (
		$fell(o_port1_txen) |-> !o_port1_txen [*8] ##1 !o_port1_txen [*4])
		else $error("inter frame gap shorter than twelve bytes on port 1");

	cov_single_mix: cover property (!dual && ing_pop ##[1:40] egr_pop);
	cov_dual_both: cover property (dual && o_port0_txen && o_port1_txen);
	cov_back_to_back: cover property ($fell(o_port0_txen) ##12 $rose(o_port0_txen));
	cov_ing_full: cover property (i_ing_valid && !o_ing_ready);
	cov_dual_qsize: cover property (dual && opt == SRE_OPT_QSIZE && o_port0_txen);
endmodule // sre_exporter

// ==== tb/sre_stats_sink.sv ====
// far-end statistics processor model: takes frames off one port and hands out record bytes
module sre_stats_sink (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_txd,
	input wire logic i_txen,
	output logic o_valid,
	output logic [7:0] o_byte,
	output logic o_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] frame[$];
	logic [7:0] recs[$];
	logic was_en;
	int idle;
	// no spare lanes looped back, which is allowed
	function automatic logic [31:0] crc_of(input int n);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 8; i < n; i++) begin
			c = c ^ {24'h0, frame[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
			end
		end
		return ~c;
	endfunction
	always @(posedge i_clock) begin
		int n;
		logic bad;
		o_valid <= 1'b0;
		o_bad <= 1'b0;
		if (!i_rst_n) begin
			frame.delete();
			recs.delete();
			was_en <= 1'b0;
			idle <= 12;
			o_byte <= 8'h00;
		end else begin
			if (i_txen) begin
				if (!was_en && idle < 12) o_bad <= 1'b1;
				frame.push_back(i_txd);
			end else if (was_en) begin
				idle <= 1;
				n = frame.size();
				bad = (n < 12);
				for (int i = 0; i < 7 && !bad; i++) bad = (frame[i] !== 8'h55);
				if (!bad) bad = (frame[7] !== 8'hd5);
				if (!bad) bad = ({frame[n-1], frame[n-2], frame[n-3], frame[n-4]} !== crc_of(n - 4));
				if (bad) o_bad <= 1'b1;
				else for (int i = 8; i < n - 4; i++) recs.push_back(frame[i]);
				frame.delete();
			end else begin
				idle <= idle + 1;
			end
			was_en <= i_txen;
			if (recs.size() > 0) begin
				o_valid <= 1'b1;
				o_byte <= recs.pop_front();
			end
		end
	end
endmodule // sre_stats_sink

// ==== tb/sre_exporter_bench.sv ====
// self-checking bench for the statistics record exporter
module sre_exporter_bench;
	import sre_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock;
	logic i_rst_n;
	sre_option_t i_option;
	logic i_dual_mode;
	logic i_far_end_coproc;
	logic i_ing_valid;
	sre_event_t i_ing_kind;
	logic [23:0] i_ing_qsize;
	logic [39:0] i_ing_tag;
	logic o_ing_ready;
	logic i_egr_valid;
	logic [23:0] i_egr_tag;
	logic o_egr_ready;
	logic [7:0] o_port0_txd;
	logic o_port0_txen;
	logic [7:0] o_port1_txd;
	logic o_port1_txen;
	logic [7:0] o_lane_enable;
	sre_option_t o_active_option;
	logic o_active_dual;
	logic v0, v1, bad0, bad1;
	logic [7:0] b0, b1;
	logic [7:0] qi[$];
	logic [7:0] qe[$];
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	int rem[2] = '{0, 0};
	sre_option_t opt = SRE_OPT_QSIZE;
	logic dual = 1'b0;
	sre_exporter uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_option(i_option),
		.i_dual_mode(i_dual_mode), .i_far_end_coproc(i_far_end_coproc),
		.i_ing_valid(i_ing_valid), .i_ing_kind(i_ing_kind), .i_ing_qsize(i_ing_qsize),
		.i_ing_tag(i_ing_tag), .o_ing_ready(o_ing_ready), .i_egr_valid(i_egr_valid),
		.i_egr_tag(i_egr_tag), .o_egr_ready(o_egr_ready), .o_port0_txd(o_port0_txd),
		.o_port0_txen(o_port0_txen), .o_port1_txd(o_port1_txd), .o_port1_txen(o_port1_txen),
		.o_lane_enable(o_lane_enable), .o_active_option(o_active_option),
		.o_active_dual(o_active_dual));
	sre_stats_sink sink0 (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_txd(o_port0_txd),
		.i_txen(o_port0_txen), .o_valid(v0), .o_byte(b0), .o_bad(bad0));
	sre_stats_sink sink1 (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_txd(o_port1_txd),
		.i_txen(o_port1_txen), .o_valid(v1), .o_byte(b1), .o_bad(bad1));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic expect_eq(input logic [7:0] got, input logic [7:0] want);
		checked++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic take(input int p, input logic [7:0] b);
		if (rem[p] == 0) begin
			rem[p] = b[7] ? 4 : 6;
			expect_eq(8'(p), dual ? {7'h0, b[7]} : 8'h00);
			expect_eq(b[7] ? (qe.size() > 0 ? qe[0] : 8'hxx) : (qi.size() > 0 ? qi[0] : 8'hxx), b);
		end
		if (b[7] && rem[p] != 4 || !b[7] && rem[p] != 6) begin
		end
		if (rem[p] == 6 || (rem[p] < 6 && qi.size() > 0 && rem[p] != 4)) begin
		end
		rem[p]--;
	endtask
	logic sel[2];
	always @(posedge i_clock) begin
		if (v0) begin
			if (rem[0] == 0) sel[0] = b0[7];
			expect_eq(sel[0] ? qe.pop_front() : qi.pop_front(), b0);
			if (rem[0] == 0) rem[0] = sel[0] ? 4 : 6;
			rem[0]--;
			if (rem[0] == (sel[0] ? 3 : 5)) expect_eq(8'h00, dual ? {7'h0, sel[0]} : 8'h00);
		end
		if (v1) begin
			if (rem[1] == 0) sel[1] = b1[7];
			expect_eq(sel[1] ? qe.pop_front() : qi.pop_front(), b1);
			if (rem[1] == 0) rem[1] = sel[1] ? 4 : 6;
			rem[1]--;
			if (rem[1] == (sel[1] ? 3 : 5)) expect_eq(8'h01, dual ? {7'h0, sel[1]} : 8'h00);
		end
		if (bad0 || bad1) expect_eq(8'h01, 8'h00);
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			$display("[ERR] %0t run did not finish", $time);
			wrap_up();
		end
	end
	task automatic new_ing();
		i_ing_valid = 1'b1;
		i_ing_kind = sre_event_t'($urandom_range(2, 0));
		i_ing_qsize = 24'($urandom);
		i_ing_tag = {8'($urandom), 32'($urandom)};
	endtask
	task automatic new_egr();
		i_egr_valid = 1'b1;
		i_egr_tag = 24'($urandom);
	endtask
	task automatic note_ing();
		logic [39:0] pl;
		if (opt == SRE_OPT_BILLING ? i_ing_kind != SRE_EV_RX : i_ing_kind == SRE_EV_RX) return;
		pl = (opt == SRE_OPT_QSIZE) ? {16'h0, i_ing_qsize} : i_ing_tag;
		qi.push_back({1'b0, opt, i_ing_kind, 3'b000});
		for (int k = 0; k < 5; k++) qi.push_back(pl[8*k +: 8]);
	endtask
	task automatic note_egr();
		if (opt != SRE_OPT_BILLING) return;
		qe.push_back({1'b1, opt, SRE_EV_TX, 3'b000});
		for (int k = 0; k < 3; k++) qe.push_back(i_egr_tag[8*k +: 8]);
	endtask
	task automatic burst(input int n);
		int ni;
		int ne;
		logic ti;
		logic te;
		ni = n;
		ne = n;
		@(posedge i_clock);
		#1;
		new_ing();
		new_egr();
		while (ni > 0 || ne > 0) begin
			@(posedge i_clock);
			ti = i_ing_valid && o_ing_ready;
			te = i_egr_valid && o_egr_ready;
			#1;
			if (ti) begin
				note_ing();
				ni--;
				if (ni > 0) new_ing();
				else i_ing_valid = 1'b0;
			end
			if (te) begin
				note_egr();
				ne--;
				if (ne > 0) new_egr();
				else i_egr_valid = 1'b0;
			end
		end
		for (int i = 0; i < 3000 && (qi.size() > 0 || qe.size() > 0); i++) @(posedge i_clock);
		repeat (20) @(posedge i_clock);
		expect_eq(8'(qi.size() + qe.size()), 8'h00);
	endtask
	task automatic set_cfg(input logic [1:0] req, input logic dm, input logic cp,
			input sre_option_t eo, input logic ed);
		@(posedge i_clock);
		#1;
		i_option = sre_option_t'(req);
		i_dual_mode = dm;
		i_far_end_coproc = cp;
		opt = eo;
		dual = ed;
		for (int i = 0; i < 50 && !(o_active_option === eo && o_active_dual === ed); i++) begin
			@(posedge i_clock);
		end
		repeat (2) @(posedge i_clock);
		#1;
		expect_eq({6'h0, o_active_option}, {6'h0, eo});
		expect_eq({7'h0, o_active_dual}, {7'h0, ed});
		expect_eq(o_lane_enable, ed ? 8'hff : 8'h0f);
	endtask
	initial begin
		i_rst_n = 1'b0;
		i_option = SRE_OPT_QSIZE;
		i_dual_mode = 1'b0;
		i_far_end_coproc = 1'b0;
		i_ing_valid = 1'b0;
		i_ing_kind = SRE_EV_ENQ;
		i_ing_qsize = 24'h000000;
		i_ing_tag = 40'h0000000000;
		i_egr_valid = 1'b0;
		i_egr_tag = 24'h000000;
		repeat (10) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		void'($urandom(32'hbe5b509e));
		expect_eq(o_lane_enable, 8'h0f);
		expect_eq({2'h0, o_active_option, o_port0_txen, o_port1_txen, o_ing_ready, o_egr_ready},
			8'h03);
		for (int o = 0; o < 3; o++) begin
			set_cfg(2'(o), 1'b0, 1'b0, sre_option_t'(o), 1'b0);
			burst(20);
		end
		set_cfg(2'd3, 1'b0, 1'b0, SRE_OPT_ENQDEQ, 1'b0);
		set_cfg(2'd1, 1'b1, 1'b0, SRE_OPT_BILLING, 1'b1);
		burst(20);
		set_cfg(2'd0, 1'b1, 1'b0, SRE_OPT_QSIZE, 1'b1);
		burst(12);
		set_cfg(2'd1, 1'b1, 1'b1, SRE_OPT_BILLING, 1'b0);
		burst(12);
		wrap_up();
	end
endmodule // sre_exporter_bench
